// *** include/csia_pkg.sv ***
// constants and carriers for the status/control and init-address registers
`default_nettype none
package csia_pkg;

    // register index values selected through the index port
    localparam logic [7:0] IDX_STATUS_CTRL = 8'h00;
    localparam logic [7:0] IDX_INIT_ADDR_LO = 8'h01;
    localparam logic [7:0] IDX_INIT_ADDR_HI = 8'h02;
    localparam logic [7:0] IDX_INIT_ADDR_HI_ALIAS = 8'h11;
    localparam logic [7:0] IDX_RESET = 8'h00;

    // status/control word bit positions
    localparam int B_ERR_SUM = 15;
    localparam int B_COLL_ERR = 13;
    localparam int B_MISSED = 12;
    localparam int B_BUS_TMO = 11;
    localparam int B_RX_DONE = 10;
    localparam int B_TX_DONE = 9;
    localparam int B_INIT_DONE = 8;
    localparam int B_IRQ_SUM = 7;
    localparam int B_IRQ_EN = 6;
    localparam int B_RX_ACT = 5;
    localparam int B_TX_ACT = 4;
    localparam int B_TX_POLL = 3;
    localparam int B_HALT = 2;
    localparam int B_RUN = 1;
    localparam int B_SETUP = 0;

    // field layout of the address registers
    localparam int ADDR_FIELD_W = 16;
    localparam int HI_UPPER_LSB = 8;
    localparam int BYTE_W = 8;

    // bus timeout: programmed in units of 100 ns
    localparam int CLK_PERIOD_NS = 20;
    localparam int TIMEOUT_UNIT_NS = 100;
    localparam int TIMEOUT_TICK_CYCLES = (TIMEOUT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] BUS_TIMEOUT_DEFAULT = 16'h0600; // 153.6 us in 100 ns units
    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

    // event pulses from the datapath
    typedef struct packed {
        logic missed_frame;
        logic rx_desc_done;
        logic rx_desc_first;
        logic rx_desc_last;
        logic tx_frame_done;
        logic tx_frame_ok;
        logic init_read_done;
        logic tx_underflow;
        logic tx_desc_fetch;
    } csia_event_s;

    // configuration bits held in neighbouring registers
    typedef struct packed {
        logic missed_frame_mask;
        logic bus_timeout_mask;
        logic rx_done_mask;
        logic tx_done_mask;
        logic init_done_mask;
        logic tx_ok_irq_suppress;
        logic lookahead_enable;
        logic underflow_keep_tx;
        logic rx_disable;
        logic tx_disable;
        logic tx_poll_disable;
        logic sw_struct_width32;
        logic suspend_state;
    } csia_cfg_s;

endpackage
`default_nettype wire

// *** core/csia_bus_timer.sv ***
// bus grant timeout counter for the status block
`timescale 1ns/1ns
`default_nettype none
module csia_bus_timer
    import csia_pkg::*;
#(
    parameter int TICK_CYCLES = TIMEOUT_TICK_CYCLES
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic clear,
    input wire logic req,
    input wire logic gnt,
    input wire logic [15:0] limit,
    output logic timeout
);
    logic [7:0] tick_q;
    logic [15:0] units_q;
    logic fired_q;
    logic waiting;
    logic tick_end;

    assign waiting = req && !gnt && !clear;
    assign tick_end = (tick_q == 8'(TICK_CYCLES - 1));

    // prescaler and unit count run only while a request waits
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tick_q <= 8'h00;
            units_q <= 16'h0000;
        end
        else if (!waiting)
        begin
            tick_q <= 8'h00;
            units_q <= 16'h0000;
        end
        else if (tick_end)
        begin
            tick_q <= 8'h00;
            if (units_q != 16'hffff)
                units_q <= units_q + 16'h0001;
        end
        else
            tick_q <= tick_q + 8'h01;
    end

    // one pulse per waiting period; a zero limit never fires
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            fired_q <= 1'b0;
        else if (!waiting)
            fired_q <= 1'b0;
        else if (timeout)
            fired_q <= 1'b1;
    end

    assign timeout = waiting && !fired_q && (limit != 16'h0000) && (units_q == limit);
endmodule
`default_nettype wire

// *** core/csia_regs.sv ***
// status/control word and init-block address registers behind the index/data port
// What this block does
// (R1) cause flags clear on write-one, ignore zero, clear on resets or halt
// (R2) bus timeout error sets when a request waits past programmed grant time
// (R3) bus timeout interrupts if enabled and unmasked; always sets error summary
// (R4) rx done sets on last descriptor, also first when lookahead enabled
// (R5) tx done sets when last transmit descriptor released, success or error
// (R6) tx done stays clear for successful frames when suppression is on
// (R7) init done sets once the init block has been read
// (R8) interrupt summary read-only, set while any allowed cause is active
// (R9) interrupt pin follows summary and enable; system and sleep bypass enable
// (R10) global enable takes written value; cleared by resets and halt
// (R11) rx active sets after run unless disabled; waits for init if both
// (R12) tx active like rx; also clears on underflow unless keep-tx set
// (R13) tx poll demand clears if tx inactive, on descriptor fetch, resets, halt
// (R14) software must write tx poll demand when automatic polling is off
// (R15) halt stops DMA until run or setup; set by write or reset; wins
// (R16) run clears halt, enables traffic; setup runs first if written together
// (R17) setup clears halt, starts init read, stays set until resets or halt
// (R18) init address writable/readable only halted or suspended; survives resets
// (R19) software keeps init address bits one and zero at zero
// (R20) narrow structures: upper byte appended and forced into stored pointers
// (R21) wide structures: upper byte only tops the init block address
// (R22) writing the high address register also updates its alias
// (R23) error summary is read-only OR of collision, missed frame, bus timeout
// (R24) missed frame interrupts if enabled and unmasked; always sets error summary
// (R25) registers reached through data port at index last written
`timescale 1ns/1ns
`default_nettype none
module csia_regs
#(
    parameter int TICK_CYCLES = csia_pkg::TIMEOUT_TICK_CYCLES
)
(
    input wire logic MCLK_IN,
    input wire logic RST_B_IN,
    input wire logic SOFT_RESET_IN,
    input wire logic REG_INDEX_WR_IN,
    input wire logic REG_DATA_WR_IN,
    input wire logic REG_DATA_RD_IN,
    input wire logic [31:0] REG_WDATA_IN,
    output logic [31:0] REG_RDATA_OUT,
    output logic REG_RVALID_OUT,
    input wire csia_pkg::csia_event_s EVENT_IN,
    input wire csia_pkg::csia_cfg_s CFG_IN,
    input wire logic COLLISION_TEST_ERROR_IN,
    input wire logic SYSTEM_ERROR_FLAG_IN,
    input wire logic SLEEP_EVENT_FLAG_IN,
    input wire logic OTHER_IRQ_IN,
    input wire logic BUS_REQ_IN,
    input wire logic BUS_GNT_IN,
    input wire logic [15:0] BUS_TIMEOUT_REG_IN,
    output logic IRQ_B_OUT,
    output logic HALT_OUT,
    output logic RUN_OUT,
    output logic SETUP_OUT,
    output logic INIT_FETCH_OUT,
    output logic RX_ACTIVE_OUT,
    output logic TX_ACTIVE_OUT,
    output logic TX_POLL_OUT,
    output logic [31:0] INIT_ADDR_OUT,
    output logic [7:0] UPPER_ADDR_OUT,
    output logic UPPER_APPEND_OUT
);
    import csia_pkg::*;

    logic [7:0] index_q;
    logic missed_q, bus_tmo_q, rx_done_q, tx_done_q, init_done_q;
    logic irq_en_q, rx_act_q, tx_act_q, tx_poll_q;
    logic halt_q, run_q, setup_q;
    logic init_busy_q, start_wait_q;
    logic addr_valid_q;
    logic [15:0] addr_lo_q;
    logic [15:0] addr_hi_q;
    logic [15:0] addr_hi_alias_q;
    logic [31:0] rdata_q;
    logic rvalid_q;

    logic wr_ctrl, wr_lo, wr_hi, wr_alias;
    logic addr_open;
    logic halt_wr, run_wr, setup_wr;
    logic clear_all;
    logic bus_tmo_evt, rx_done_evt, tx_done_evt;
    logic start_now;
    logic irq_summary;
    logic err_summary;
    logic [15:0] status_word;

    // decode of data-port writes at the current index
    assign wr_ctrl = REG_DATA_WR_IN && (index_q == IDX_STATUS_CTRL); // R25
    assign wr_lo = REG_DATA_WR_IN && (index_q == IDX_INIT_ADDR_LO) && addr_open;
    assign wr_hi = REG_DATA_WR_IN && (index_q == IDX_INIT_ADDR_HI) && addr_open;
    assign wr_alias = REG_DATA_WR_IN && (index_q == IDX_INIT_ADDR_HI_ALIAS) && addr_open;

    // address registers open only while halted or suspended
    assign addr_open = halt_q || CFG_IN.suspend_state; // R18

    // command decode; a halt in the same write overrides run and setup
    assign halt_wr = wr_ctrl && REG_WDATA_IN[B_HALT]; // R15
    assign run_wr = wr_ctrl && REG_WDATA_IN[B_RUN] && !REG_WDATA_IN[B_HALT]; // R16
    assign setup_wr = wr_ctrl && REG_WDATA_IN[B_SETUP] && !REG_WDATA_IN[B_HALT]; // R17
    assign clear_all = SOFT_RESET_IN || halt_wr;

    // index port, cleared by either reset, untouched by halt
    always_ff @(posedge MCLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            index_q <= IDX_RESET;
        else if (SOFT_RESET_IN)
            index_q <= IDX_RESET;
        else if (REG_INDEX_WR_IN)
            index_q <= REG_WDATA_IN[7:0]; // R25
    end

    // grant timeout measured by the timer
    csia_bus_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_bus_timer (
        .clk(MCLK_IN),
        .rst_b(RST_B_IN),
        .clear(SOFT_RESET_IN),
        .req(BUS_REQ_IN),
        .gnt(BUS_GNT_IN),
        .limit(BUS_TIMEOUT_REG_IN),
        .timeout(bus_tmo_evt) // R2
    );

    // event qualification for the cause flags
    assign rx_done_evt = EVENT_IN.rx_desc_done && (EVENT_IN.rx_desc_last ||
        (EVENT_IN.rx_desc_first && CFG_IN.lookahead_enable)); // R4
    assign tx_done_evt = EVENT_IN.tx_frame_done &&
        !(CFG_IN.tx_ok_irq_suppress && EVENT_IN.tx_frame_ok); // R5 R6

    // cause flags: an event beats write-one-clear,
    // while reset and halt clear unconditionally
    always_ff @(posedge MCLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            missed_q <= 1'b0;
            bus_tmo_q <= 1'b0;
            rx_done_q <= 1'b0;
            tx_done_q <= 1'b0;
            init_done_q <= 1'b0;
        end
        else if (clear_all)
        begin
            missed_q <= 1'b0; // R1
            bus_tmo_q <= 1'b0;
            rx_done_q <= 1'b0;
            tx_done_q <= 1'b0;
            init_done_q <= 1'b0;
        end
        else
        begin
            missed_q <= EVENT_IN.missed_frame ||
                (missed_q && !(wr_ctrl && REG_WDATA_IN[B_MISSED])); // R1
            bus_tmo_q <= bus_tmo_evt ||
                (bus_tmo_q && !(wr_ctrl && REG_WDATA_IN[B_BUS_TMO])); // R1 R2
            rx_done_q <= rx_done_evt ||
                (rx_done_q && !(wr_ctrl && REG_WDATA_IN[B_RX_DONE])); // R1 R4
            tx_done_q <= tx_done_evt ||
                (tx_done_q && !(wr_ctrl && REG_WDATA_IN[B_TX_DONE])); // R1 R5
            init_done_q <= (EVENT_IN.init_read_done && init_busy_q) ||
                (init_done_q && !(wr_ctrl && REG_WDATA_IN[B_INIT_DONE])); // R1 R7
        end
    end

    // global interrupt enable follows the written value
    always_ff @(posedge MCLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            irq_en_q <= 1'b0;
        else if (clear_all)
            irq_en_q <= 1'b0; // R10
        else if (wr_ctrl)
            irq_en_q <= REG_WDATA_IN[B_IRQ_EN]; // R10
    end

    // halt is set by reset and stays until run or setup is written
    always_ff @(posedge MCLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            halt_q <= 1'b1;
        else if (clear_all)
            halt_q <= 1'b1; // R15
        else if (run_wr || setup_wr)
            halt_q <= 1'b0; // R16 R17
    end

    // run and setup are sticky command bits; writes of zero do nothing
    always_ff @(posedge MCLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            run_q <= 1'b0;
            setup_q <= 1'b0;
        end
        else if (clear_all)
        begin
            run_q <= 1'b0;
            setup_q <= 1'b0;
        end
        else
        begin
            if (run_wr)
                run_q <= 1'b1; // R16
            if (setup_wr)
                setup_q <= 1'b1; // R17
        end
    end

    // init sequencing: the block read must finish before a paired start
    always_ff @(posedge MCLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            init_busy_q <= 1'b0;
            start_wait_q <= 1'b0;
        end
        else if (clear_all)
        begin
            init_busy_q <= 1'b0;
            start_wait_q <= 1'b0;
        end
        else if (setup_wr)
        begin
            init_busy_q <= 1'b1; // R17
            start_wait_q <= run_wr || start_wait_q; // R16
        end
        else if (init_busy_q && EVENT_IN.init_read_done)
        begin
            init_busy_q <= 1'b0;
            start_wait_q <= 1'b0;
        end
        else if (run_wr && init_busy_q)
            start_wait_q <= 1'b1;
    end

    // start either right away or when the pending init read completes
    assign start_now = (run_wr && !setup_wr && !init_busy_q) ||
        (start_wait_q && init_busy_q && EVENT_IN.init_read_done && !setup_wr); // R11 R12

    // receive active indicator
    always_ff @(posedge MCLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            rx_act_q <= 1'b0;
        else if (clear_all)
            rx_act_q <= 1'b0; // R11
        else if (start_now && !CFG_IN.rx_disable)
            rx_act_q <= 1'b1; // R11
    end

    // transmit active indicator; underflow stops it unless kept running
    always_ff @(posedge MCLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            tx_act_q <= 1'b0;
        else if (clear_all)
            tx_act_q <= 1'b0; // R12
        else if (start_now && !CFG_IN.tx_disable)
            tx_act_q <= 1'b1; // R12
        else if (EVENT_IN.tx_underflow && !CFG_IN.underflow_keep_tx)
            tx_act_q <= 1'b0; // R12
    end

    // transmit poll demand; ignored while the transmitter is off, so the
    // bit then reads back zero without any ring access
    always_ff @(posedge MCLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            tx_poll_q <= 1'b0;
        else if (clear_all)
            tx_poll_q <= 1'b0; // R13
        else if (!tx_act_q)
            tx_poll_q <= 1'b0; // R13
        else if (wr_ctrl && REG_WDATA_IN[B_TX_POLL])
            tx_poll_q <= 1'b1; // R13 R14
        else if (EVENT_IN.tx_desc_fetch)
            tx_poll_q <= 1'b0; // R13
    end

    // no reset here, so contents survive both resets and read back;
    // the valid flag only keeps the pointer outputs defined
    always_ff @(posedge MCLK_IN)
    begin
        if (wr_lo)
            addr_lo_q <= REG_WDATA_IN[ADDR_FIELD_W-1:0]; // R18
        if (wr_hi)
            addr_hi_q <= REG_WDATA_IN[ADDR_FIELD_W-1:0]; // R18
        if (wr_hi || wr_alias)
            addr_hi_alias_q <= REG_WDATA_IN[ADDR_FIELD_W-1:0]; // R22
    end

    always_ff @(posedge MCLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            addr_valid_q <= 1'b0;
        else if (wr_lo || wr_hi)
            addr_valid_q <= 1'b1;
    end

    // interrupt summary, error summary and the pin
    assign irq_summary = (missed_q && !CFG_IN.missed_frame_mask) || // R24
        (bus_tmo_q && !CFG_IN.bus_timeout_mask) || // R3
        (rx_done_q && !CFG_IN.rx_done_mask) || // R4
        (tx_done_q && !CFG_IN.tx_done_mask) || // R5
        (init_done_q && !CFG_IN.init_done_mask) || // R7
        SYSTEM_ERROR_FLAG_IN || SLEEP_EVENT_FLAG_IN || OTHER_IRQ_IN; // R8
    assign err_summary = COLLISION_TEST_ERROR_IN || missed_q || bus_tmo_q; // R23 R3 R24
    assign IRQ_B_OUT = !((irq_summary && irq_en_q) ||
        SYSTEM_ERROR_FLAG_IN || SLEEP_EVENT_FLAG_IN); // R9 R10

    // assembled status word; reserved bit reads zero
    always_comb
    begin
        status_word = 16'h0000;
        status_word[B_ERR_SUM] = err_summary; // R23
        status_word[B_COLL_ERR] = COLLISION_TEST_ERROR_IN;
        status_word[B_MISSED] = missed_q;
        status_word[B_BUS_TMO] = bus_tmo_q;
        status_word[B_RX_DONE] = rx_done_q;
        status_word[B_TX_DONE] = tx_done_q;
        status_word[B_INIT_DONE] = init_done_q;
        status_word[B_IRQ_SUM] = irq_summary; // R8
        status_word[B_IRQ_EN] = irq_en_q;
        status_word[B_RX_ACT] = rx_act_q;
        status_word[B_TX_ACT] = tx_act_q;
        status_word[B_TX_POLL] = tx_poll_q;
        status_word[B_HALT] = halt_q;
        status_word[B_RUN] = run_q;
        status_word[B_SETUP] = setup_q;
    end

    // registered read data, one cycle after the read strobe
    // closed or unmapped registers read as zero rather than stale data
    always_ff @(posedge MCLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            rdata_q <= DATA_ZERO;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= REG_DATA_RD_IN;
            if (REG_DATA_RD_IN)
            begin
                case (index_q) // R25
                    IDX_STATUS_CTRL: rdata_q <= {16'h0000, status_word};
                    IDX_INIT_ADDR_LO: rdata_q <= addr_open ?
                        {16'h0000, addr_lo_q} : DATA_ZERO; // R18
                    IDX_INIT_ADDR_HI: rdata_q <= addr_open ?
                        {16'h0000, addr_hi_q} : DATA_ZERO; // R18
                    IDX_INIT_ADDR_HI_ALIAS: rdata_q <= addr_open ?
                        {16'h0000, addr_hi_alias_q} : DATA_ZERO; // R22
                    default: rdata_q <= DATA_ZERO;
                endcase
            end
        end
    end

    assign REG_RDATA_OUT = rdata_q;
    assign REG_RVALID_OUT = rvalid_q;

    // command state to the DMA engine
    assign HALT_OUT = halt_q; // R15
    assign RUN_OUT = run_q;
    assign SETUP_OUT = setup_q;
    assign INIT_FETCH_OUT = init_busy_q; // R17
    assign RX_ACTIVE_OUT = rx_act_q;
    assign TX_ACTIVE_OUT = tx_act_q;
    assign TX_POLL_OUT = tx_poll_q;

    // upper byte tops the init address; append only for narrow structures
    assign INIT_ADDR_OUT = addr_valid_q ?
        {addr_hi_q[ADDR_FIELD_W-1:HI_UPPER_LSB], addr_hi_q[BYTE_W-1:0], addr_lo_q} :
        DATA_ZERO; // R20 R21
    assign UPPER_ADDR_OUT = addr_valid_q ?
        addr_hi_q[ADDR_FIELD_W-1:HI_UPPER_LSB] : 8'h00; // R20
    assign UPPER_APPEND_OUT = !CFG_IN.sw_struct_width32; // R20 R21
endmodule
`default_nettype wire

// *** sim/csia_monitor.sv ***
// assertion checker bound to the status/control register block
`timescale 1ns/1ns
`default_nettype none
module csia_monitor
(
    input wire logic MCLK_IN,
    input wire logic RST_B_IN,
    input wire logic SOFT_RESET_IN,
    input wire logic REG_INDEX_WR_IN,
    input wire logic REG_DATA_WR_IN,
    input wire logic REG_DATA_RD_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic REG_RVALID_OUT,
    input wire csia_pkg::csia_event_s EVENT_IN,
    input wire csia_pkg::csia_cfg_s CFG_IN,
    input wire logic SYSTEM_ERROR_FLAG_IN,
    input wire logic SLEEP_EVENT_FLAG_IN,
    input wire logic IRQ_B_OUT,
    input wire logic HALT_OUT,
    input wire logic RUN_OUT,
    input wire logic SETUP_OUT,
    input wire logic INIT_FETCH_OUT,
    input wire logic TX_ACTIVE_OUT,
    input wire logic TX_POLL_OUT,
    input wire logic [31:0] INIT_ADDR_OUT,
    input wire logic [7:0] UPPER_ADDR_OUT,
    input wire logic UPPER_APPEND_OUT
);
    import csia_pkg::*;
    logic [7:0] idx_q;
    logic cw;
    // index shadow to spot status writes
    always_ff @(posedge MCLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
            idx_q <= 8'h00;
        else if (SOFT_RESET_IN)
            idx_q <= 8'h00;
        else if (REG_INDEX_WR_IN)
            idx_q <= REG_WDATA_IN[7:0];
    end
    // soft reset beats any status write
    assign cw = REG_DATA_WR_IN && idx_q == IDX_STATUS_CTRL && !SOFT_RESET_IN;
    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_B_IN);
    a_read_latency: assert property (REG_DATA_RD_IN |=> REG_RVALID_OUT)
        else $error("no rvalid");
    a_halt_wins: assert property (cw && REG_WDATA_IN[B_HALT] |=> HALT_OUT && !RUN_OUT
        && !SETUP_OUT && !TX_ACTIVE_OUT && !TX_POLL_OUT && !INIT_FETCH_OUT)
        else $error("halt ignored");
    a_run_write: assert property (cw && REG_WDATA_IN[B_RUN] && !REG_WDATA_IN[B_HALT]
        |=> RUN_OUT && !HALT_OUT) else $error("run ignored");
    a_setup_write: assert property (cw && REG_WDATA_IN[B_SETUP] && !REG_WDATA_IN[B_HALT]
        |=> SETUP_OUT && !HALT_OUT && INIT_FETCH_OUT) else $error("setup ignored");
    a_soft_reset: assert property (SOFT_RESET_IN |=> HALT_OUT && !RUN_OUT && !SETUP_OUT)
        else $error("no soft halt");
    a_underflow_stop: assert property (EVENT_IN.tx_underflow && !CFG_IN.underflow_keep_tx
        |=> !TX_ACTIVE_OUT) else $error("tx kept on");
    a_poll_idle: assert property (!TX_ACTIVE_OUT [*2] |-> !TX_POLL_OUT)
        else $error("stale poll");
    a_irq_bypass: assert property (SYSTEM_ERROR_FLAG_IN || SLEEP_EVENT_FLAG_IN |-> !IRQ_B_OUT)
        else $error("no bypass irq");
    a_upper_byte: assert property (INIT_ADDR_OUT[31:24] == UPPER_ADDR_OUT
        && UPPER_APPEND_OUT == !CFG_IN.sw_struct_width32) else $error("upper byte wrong");
    a_addr_locked: assert property (!HALT_OUT && !CFG_IN.suspend_state
        |=> $stable(INIT_ADDR_OUT)) else $error("addr moved");
    a_fetch_ends: assert property (INIT_FETCH_OUT && EVENT_IN.init_read_done && !cw
        |=> !INIT_FETCH_OUT && SETUP_OUT) else $error("fetch stuck");
endmodule
bind csia_regs csia_monitor mon_u (.*);
`default_nettype wire

// *** sim/csia_dp_model.sv ***
// far-side model: memory answering the init-block read, and the bus arbiter
`timescale 1ns/1ns
`default_nettype none
module csia_dp_model
#(
    parameter int INIT_DLY = 6
)
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic fetch_in,
    input wire logic req_in,
    input wire logic stall_in,
    output logic done_out,
    output logic gnt_out
);
    int cnt_q;
    // the block read takes a fixed span, then one completion pulse
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            cnt_q <= 0;
            done_out <= 1'b0;
        end
        else
        begin
            done_out <= fetch_in && !done_out && cnt_q == INIT_DLY;
            cnt_q <= (fetch_in && !done_out) ? cnt_q + 1 : 0;
        end
    end
    // grant next cycle; stall withholds it so a bus wait can run out
    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            gnt_out <= 1'b0;
        else
            gnt_out <= req_in && !stall_in;
    end
endmodule
`default_nettype wire

// *** sim/controller_status_and_init_address_test.sv ***
// self-checking bench for the status/control and init-address registers
`timescale 1ns/1ns
`default_nettype none
module controller_status_and_init_address_test;
    import csia_pkg::*;
    logic clk, rst_b, srst, iwr, dwr, drd, rv, irq_b, halt, run, setup, fetch;
    logic rxa, txa, poll, app, req, gnt, stall, coll, syse, done;
    logic [31:0] wd, rdat, iaddr;
    logic [7:0] up;
    csia_event_s ev, evd;
    csia_cfg_s cfg;
    int num_errors = 0;
    int total_checks = 0;
    // cause flag table: events, config, expected bits
    logic [8:0] et [7] = '{9'h100, 9'h100, 9'h0a0, 9'h0c0, 9'h0c0, 9'h010, 9'h018};
    logic [12:0] ct [7] = '{13'h0, 13'h1000, 13'h0, 13'h0, 13'h0040, 13'h0, 13'h0080};
    logic [31:0] xt [7] = '{32'h9080, 32'h9000, 32'h0480, 32'h0, 32'h0480, 32'h0280, 32'h0};
    assign ev = evd | {6'h00, done, 2'h0};
    csia_regs #(.TICK_CYCLES(1)) dut_u (.MCLK_IN(clk), .RST_B_IN(rst_b), .SOFT_RESET_IN(srst),
        .REG_INDEX_WR_IN(iwr), .REG_DATA_WR_IN(dwr), .REG_DATA_RD_IN(drd), .REG_WDATA_IN(wd),
        .REG_RDATA_OUT(rdat), .REG_RVALID_OUT(rv), .EVENT_IN(ev), .CFG_IN(cfg),
        .COLLISION_TEST_ERROR_IN(coll), .SYSTEM_ERROR_FLAG_IN(syse), .SLEEP_EVENT_FLAG_IN(1'b0),
        .OTHER_IRQ_IN(1'b0), .BUS_REQ_IN(req), .BUS_GNT_IN(gnt), .BUS_TIMEOUT_REG_IN(16'h0004),
        .IRQ_B_OUT(irq_b), .HALT_OUT(halt), .RUN_OUT(run), .SETUP_OUT(setup),
        .INIT_FETCH_OUT(fetch), .RX_ACTIVE_OUT(rxa), .TX_ACTIVE_OUT(txa), .TX_POLL_OUT(poll),
        .INIT_ADDR_OUT(iaddr), .UPPER_ADDR_OUT(up), .UPPER_APPEND_OUT(app));
    csia_dp_model dp_u (.clk_in(clk), .rst_b_in(rst_b), .fetch_in(fetch), .req_in(req),
        .stall_in(stall), .done_out(done), .gnt_out(gnt));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    // index write, one cycle
    task automatic ix(input logic [7:0] i);
        @(negedge clk);
        iwr = 1'b1;
        wd = {24'h0, i};
        @(negedge clk);
        iwr = 1'b0;
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        ix(i);
        dwr = 1'b1;
        wd = d;
        @(negedge clk);
        dwr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] e);
        ix(i);
        drd = 1'b1;
        @(negedge clk);
        drd = 1'b0;
        chk("rvalid", 1, rv);
        chk("rdata", e, rdat);
    endtask
    task automatic pulse(input logic [8:0] e);
        @(negedge clk);
        evd = e;
        @(negedge clk);
        evd = '0;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // bound only catches a hang
    initial
    begin
        #200000;
        num_errors++;
        test_done();
    end
    initial
    begin
        {rst_b, srst, iwr, dwr, drd, req, stall, coll, syse} = '0;
        wd = '0;
        evd = '0;
        cfg = '0;
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        rd(IDX_STATUS_CTRL, 32'h0004);
        wr(IDX_INIT_ADDR_LO, 32'h5678);
        wr(IDX_INIT_ADDR_HI, 32'hab12);
        rd(IDX_INIT_ADDR_HI_ALIAS, 32'hab12);
        rd(IDX_INIT_ADDR_LO, 32'h5678);
        rd(8'h05, 32'h0);
        chk("iaddr", 32'hab125678, iaddr);
        chk("append", 1, app);
        $display("address test done");
        wr(IDX_STATUS_CTRL, 32'h0043);
        chk("rx early", 0, rxa);
        repeat (30) if (!rxa) @(negedge clk);
        rd(IDX_STATUS_CTRL, 32'h01f3);
        chk("irq", 0, irq_b);
        wr(IDX_INIT_ADDR_LO, 32'h0);
        chk("locked", 32'hab125678, iaddr);
        rd(IDX_INIT_ADDR_LO, 32'h0);
        wr(IDX_STATUS_CTRL, 32'h0040);
        rd(IDX_STATUS_CTRL, 32'h01f3);
        wr(IDX_STATUS_CTRL, 32'h0140);
        rd(IDX_STATUS_CTRL, 32'h0073);
        $display("start test done");
        for (int i = 0; i < 7; i++)
        begin
            cfg = ct[i];
            pulse(et[i]);
            rd(IDX_STATUS_CTRL, xt[i] | 32'h0073);
            chk("irq", !xt[i][7], irq_b);
            wr(IDX_STATUS_CTRL, 32'h1f40);
        end
        coll = 1'b1;
        rd(IDX_STATUS_CTRL, 32'ha073);
        coll = 1'b0;
        cfg = 13'h0800;
        req = 1'b1;
        repeat (40) @(negedge clk);
        rd(IDX_STATUS_CTRL, 32'h0073);
        stall = 1'b1;
        repeat (40) @(negedge clk);
        req = 1'b0;
        rd(IDX_STATUS_CTRL, 32'h8873);
        chk("irq", 1, irq_b);
        $display("cause flag test done");
        pulse(9'h100);
        wr(IDX_STATUS_CTRL, 32'h0000);
        chk("irq off", 1, irq_b);
        syse = 1'b1;
        #1;
        chk("irq sys", 0, irq_b);
        syse = 1'b0;
        wr(IDX_STATUS_CTRL, 32'h0008);
        chk("poll", 1, poll);
        pulse(9'h001);
        chk("poll fetch", 0, poll);
        wr(IDX_STATUS_CTRL, 32'h0008);
        pulse(9'h002);
        chk("tx on", 0, txa);
        wr(IDX_STATUS_CTRL, 32'h0008);
        chk("poll idle", 0, poll);
        wr(IDX_STATUS_CTRL, 32'h0007);
        rd(IDX_STATUS_CTRL, 32'h0004);
        $display("control test done");
        wr(IDX_STATUS_CTRL, 32'h0002);
        chk("rx run", 1, rxa);
        @(negedge clk);
        srst = 1'b1;
        @(negedge clk);
        srst = 1'b0;
        rd(IDX_STATUS_CTRL, 32'h0004);
        wr(IDX_STATUS_CTRL, 32'h0002);
        rst_b = 1'b0;
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        rd(IDX_INIT_ADDR_LO, 32'h5678);
        rd(IDX_INIT_ADDR_HI, 32'hab12);
        $display("reset test done");
        test_done();
    end
endmodule
`default_nettype wire
